// File: dma_channel_map.sv
// Fixed wiring of a channel of either controller to its peripheral and direction.
// Assumes channel indices are channel number minus one; purely combinational.
`timescale 1ns/10ps
`include "dma_map_defines.svh"

module dma_channel_map
  import dma_map_pkg::*;
(
  // Channel select
  input  wire logic               i_usb_ctrl,
  input  wire logic [`CHAN_W-1:0] i_chan,
  // Map result
  output      flyby_type          o_flyby,
  output      source_type         o_source,
  output      ser_port_type       o_port
);

  // ----------------------------------------------------------------------
  // Serial ports pair up as B, A, C, D
  // ----------------------------------------------------------------------
  function automatic ser_port_type port_of(input logic [1:0] pair);
    unique case (pair)
      2'b00: port_of = port_b;
      2'b01: port_of = port_a;
      2'b10: port_of = port_c;
      2'b11: port_of = port_d;
    endcase
  endfunction

  always_comb begin
    o_flyby  = flyby_none;
    o_source = src_none;
    o_port   = port_of(i_chan[2:1]);
    if (!i_usb_ctrl) begin
      if (i_chan <= `IDX_SER_LAST) begin
        o_source = src_serial;
        o_flyby  = i_chan[0] ? flyby_mem_to_periph : flyby_periph_to_mem;
      end else if (i_chan == `IDX_PRN_CMD_RX || i_chan == `IDX_PRN_DATA_RX) begin
        o_source = src_printer;
        o_flyby  = flyby_periph_to_mem;
      end else if (i_chan == `IDX_PRN_DATA_TX) begin
        o_source = src_printer;
        o_flyby  = flyby_mem_to_periph;
      end
    end else begin
      if (i_chan == `IDX_USB_OUT0) begin
        o_source = src_usb;
        o_flyby  = flyby_periph_to_mem;
      end else if (i_chan == `IDX_USB_IN0) begin
        o_source = src_usb;
        o_flyby  = flyby_mem_to_periph;
      end else if (i_chan <= `IDX_USB_EP_LAST) begin
        o_source = src_usb;
        o_flyby  = flyby_either_direction;
      end
    end
  end

endmodule

// File: dma_map_checker.sv
// Concurrent checks on the ports of the status and channel map block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
`include "dma_map_defines.svh"

module dma_map_checker (
  // Clock and reset
  input wire logic                     I_CLOCK,
  input wire logic                     I_RST_N,
  // Inputs watched
  input wire logic [`CHAN_COUNT-1:0]   i_PERIPH_REQ,
  input wire logic [`CHAN_COUNT-1:0]   i_USB_REQ,
  input wire logic                     i_XFER_VALID,
  input wire logic                     i_XFER_USB,
  input wire logic [`CHAN_W-1:0]       i_XFER_CHAN,
  input wire logic                     i_RETIRE_VALID,
  input wire logic                     i_RETIRE_USB,
  input wire logic [`CHAN_W-1:0]       i_RETIRE_CHAN,
  input wire logic [1:0]               i_USB_STATE,
  input wire logic                     i_USB_BIT13,
  input wire logic                     i_USB_SETUP_SEL,
  input wire logic [`USB_FIELD_W-1:0]  i_USB_SETUP_ADDR,
  input wire logic [`USB_FIELD_W-1:0]  i_USB_EP_CONFIG,
  // Outputs watched
  input wire logic [`CHAN_COUNT-1:0]   o_PERIPH_REQ,
  input wire logic [`CHAN_COUNT-1:0]   o_USB_REQ,
  input wire logic                     o_XFER_GRANT,
  input wire logic                     o_XFER_DENY,
  input wire logic                     o_XFER_TO_PERIPH,
  input wire logic                     o_DESC_WRITE,
  input wire logic                     o_DESC_USB,
  input wire logic [`CHAN_W-1:0]       o_DESC_CHAN,
  input wire logic [`STATUS_W-1:0]     o_DESC_STATUS,
  input wire logic                     o_DESC_FULL,
  input wire logic                     o_RETIRE_DENY
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  sequence s_usb_retire;
    (i_RETIRE_VALID && i_RETIRE_USB) ##1 o_DESC_WRITE;
  endsequence
  sequence s_zero_retire;
    (i_RETIRE_VALID && !i_RETIRE_USB && ((i_RETIRE_CHAN[0] && i_RETIRE_CHAN < 4'h8) ||
      i_RETIRE_CHAN inside {4'h8, 4'ha, 4'hb})) ##1 o_DESC_WRITE;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_write_has_cause: assert property (o_DESC_WRITE |-> $past(i_RETIRE_VALID) &&
    o_DESC_CHAN == $past(i_RETIRE_CHAN)) else $error("descriptor write without retire");
  a_retire_one_answer: assert property (i_RETIRE_VALID |=> o_DESC_WRITE != o_RETIRE_DENY)
    else $error("retire answer missing or double");
  a_status_holds: assert property (!o_DESC_WRITE |-> $stable(o_DESC_STATUS))
    else $error("status changed outside retire");
  a_xfer_one_answer: assert property (i_XFER_VALID |=> o_XFER_GRANT != o_XFER_DENY)
    else $error("transfer answer missing or double");
  a_periph_req_mask: assert property (1'b1 |=> o_PERIPH_REQ ==
    ($past(i_PERIPH_REQ) & `PERIPH_USED_MASK)) else $error("peripheral request mask wrong");
  a_usb_req_mask: assert property (1'b1 |=> o_USB_REQ ==
    ($past(i_USB_REQ) & `USB_USED_MASK)) else $error("endpoint request mask wrong");
  a_usb_unused_deny: assert property (i_XFER_VALID && i_XFER_USB && i_XFER_CHAN > 4'hc
    |=> o_XFER_DENY) else $error("unused endpoint channel granted");
  a_serial_full_flag: assert property (o_DESC_WRITE && !o_DESC_USB && o_DESC_CHAN < 4'h8
    |-> o_DESC_FULL == !o_DESC_CHAN[0]) else $error("serial full flag wrong");
  a_serial_direction: assert property (o_XFER_GRANT && !$past(i_XFER_USB) &&
    $past(i_XFER_CHAN) < 4'h8 |-> o_XFER_TO_PERIPH == $past(i_XFER_CHAN[0]))
    else $error("serial direction wrong");
  a_zero_status: assert property (s_zero_retire |-> o_DESC_STATUS == 16'h0000)
    else $error("transmit or printer status not zero");
  a_usb_status_word: assert property (s_usb_retire |-> o_DESC_STATUS ==
    {$past(i_USB_STATE), $past(i_USB_BIT13), $past(i_USB_SETUP_SEL), $past(i_USB_SETUP_SEL) ?
    $past(i_USB_SETUP_ADDR) : $past(i_USB_EP_CONFIG)}) else $error("endpoint status wrong");
endmodule

bind dma_status_channel_map dma_map_checker i_checker (
  .I_CLOCK, .I_RST_N, .i_PERIPH_REQ, .i_USB_REQ, .i_XFER_VALID, .i_XFER_USB, .i_XFER_CHAN,
  .i_RETIRE_VALID, .i_RETIRE_USB, .i_RETIRE_CHAN, .i_USB_STATE, .i_USB_BIT13,
  .i_USB_SETUP_SEL, .i_USB_SETUP_ADDR, .i_USB_EP_CONFIG, .o_PERIPH_REQ, .o_USB_REQ,
  .o_XFER_GRANT, .o_XFER_DENY, .o_XFER_TO_PERIPH, .o_DESC_WRITE, .o_DESC_USB, .o_DESC_CHAN,
  .o_DESC_STATUS, .o_DESC_FULL, .o_RETIRE_DENY
);

// File: dma_map_defines.svh
// Widths, channel indices, reset values and fixed masks of the status and channel map.
// Assumes inclusion by bare name from the design modules, the checker and the bench.
`ifndef DMA_MAP_DEFINES_SVH
`define DMA_MAP_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths and channel counts
// ----------------------------------------------------------------------
`define STATUS_W        16
`define CHAN_COUNT      16
`define CHAN_W          4
`define USB_FIELD_W     12
`define USB_EP_COUNT    11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define STATUS_RESET    16'h0000
`define REQ_RESET       16'h0000

// ----------------------------------------------------------------------
// Channels wired to a request source, bit n is channel n+1
// ----------------------------------------------------------------------
`define PERIPH_USED_MASK 16'h0dff
`define USB_USED_MASK    16'h1fff

// ----------------------------------------------------------------------
// Channel indices (channel number minus one)
// ----------------------------------------------------------------------
`define IDX_SER_LAST     4'h7
`define IDX_PRN_CMD_RX   4'h8
`define IDX_PRN_DATA_RX  4'ha
`define IDX_PRN_DATA_TX  4'hb
`define IDX_USB_OUT0     4'h0
`define IDX_USB_IN0      4'h1
`define IDX_USB_EP_FIRST 4'h2
`define IDX_USB_EP_LAST  4'hc

`endif

// File: dma_map_pkg.sv
// Types shared by the status packer, the channel map and the top module.
// Assumes dma_map_defines.svh is reachable on the include path.
package dma_map_pkg;

  // ----------------------------------------------------------------------
  // Fly-by direction type of a channel
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    flyby_none             = 2'b00,
    flyby_mem_to_periph    = 2'b01,
    flyby_periph_to_mem    = 2'b10,
    flyby_either_direction = 2'b11
  } flyby_type;

  // ----------------------------------------------------------------------
  // Peripheral kind behind a channel
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    src_none    = 2'b00,
    src_serial  = 2'b01,
    src_printer = 2'b10,
    src_usb     = 2'b11
  } source_type;

  // ----------------------------------------------------------------------
  // Serial port letter
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    port_a = 2'b00,
    port_b = 2'b01,
    port_c = 2'b10,
    port_d = 2'b11
  } ser_port_type;

endpackage

// File: dma_status_channel_map.sv
// Descriptor retire status and fixed channel map of the two fly-by DMA controllers.
// Assumes descriptor fetch and memory moves happen outside; one clock, async reset.
`timescale 1ns/10ps
`include "dma_map_defines.svh"

module dma_status_channel_map
  import dma_map_pkg::*;
(
  // Clock and reset
  input  wire logic                    I_CLOCK,
  input  wire logic                    I_RST_N,
  // Raw peripheral request lines, bit n is channel n+1
  input  wire logic [`CHAN_COUNT-1:0]  i_PERIPH_REQ,
  input  wire logic [`CHAN_COUNT-1:0]  i_USB_REQ,
  // Transfer start check
  input  wire logic                    i_XFER_VALID,
  input  wire logic                    i_XFER_USB,
  input  wire logic [`CHAN_W-1:0]      i_XFER_CHAN,
  input  wire logic                    i_XFER_FULL,
  // Descriptor retire
  input  wire logic                    i_RETIRE_VALID,
  input  wire logic                    i_RETIRE_USB,
  input  wire logic [`CHAN_W-1:0]      i_RETIRE_CHAN,
  input  wire logic                    i_RETIRE_FULL,
  // Serial configuration, bit per port A to D
  input  wire logic [3:0]              i_SER_SPI_MODE,
  // Serial receive report
  input  wire logic [3:0]              i_SER_MATCH,
  input  wire logic                    i_SER_BUF_GAP,
  input  wire logic                    i_SER_CHAR_GAP,
  input  wire logic                    i_SER_BREAK,
  input  wire logic                    i_SER_FRAME_ERR,
  input  wire logic                    i_SER_PARITY_ERR,
  input  wire logic                    i_SER_OVERRUN,
  // Endpoint report and direction of endpoints 1 to 11
  input  wire logic [1:0]              i_USB_STATE,
  input  wire logic                    i_USB_BIT13,
  input  wire logic                    i_USB_SETUP_SEL,
  input  wire logic [`USB_FIELD_W-1:0] i_USB_SETUP_ADDR,
  input  wire logic [`USB_FIELD_W-1:0] i_USB_EP_CONFIG,
  input  wire logic [`USB_EP_COUNT-1:0] i_USB_EP_TO_HOST,
  // Masked request lines
  output      logic [`CHAN_COUNT-1:0]  o_PERIPH_REQ,
  output      logic [`CHAN_COUNT-1:0]  o_USB_REQ,
  // Transfer start answer
  output      logic                    o_XFER_GRANT,
  output      logic                    o_XFER_DENY,
  output      logic                    o_XFER_TO_PERIPH,
  // Descriptor write
  output      logic                    o_DESC_WRITE,
  output      logic                    o_DESC_USB,
  output      logic [`CHAN_W-1:0]      o_DESC_CHAN,
  output      logic [`STATUS_W-1:0]    o_DESC_STATUS,
  output      logic                    o_DESC_FULL,
  output      logic                    o_RETIRE_DENY
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`CHAN_COUNT-1:0] periph_req;
    logic [`CHAN_COUNT-1:0] usb_req;
    logic                   xfer_grant;
    logic                   xfer_deny;
    logic                   xfer_to_periph;
    logic                   desc_write;
    logic                   desc_usb;
    logic [`CHAN_W-1:0]     desc_chan;
    logic [`STATUS_W-1:0]   desc_status;
    logic                   desc_full;
    logic                   retire_deny;
  } state_type;

  state_type q;
  state_type d;

  // ----------------------------------------------------------------------
  // Channel map lookups
  // ----------------------------------------------------------------------
  flyby_type    xfer_flyby;
  source_type   xfer_source;
  flyby_type    ret_flyby;
  source_type   ret_source;
  ser_port_type ret_port;
  logic [`STATUS_W-1:0] ret_status;
  logic         ret_rx;
  logic         xfer_fill;

  dma_channel_map u_xfer_map (
    .i_usb_ctrl (i_XFER_USB),
    .i_chan     (i_XFER_CHAN),
    .o_flyby    (xfer_flyby),
    .o_source   (xfer_source),
    .o_port     ()
  );

  dma_channel_map u_ret_map (
    .i_usb_ctrl (i_RETIRE_USB),
    .i_chan     (i_RETIRE_CHAN),
    .o_flyby    (ret_flyby),
    .o_source   (ret_source),
    .o_port     (ret_port)
  );

  // ----------------------------------------------------------------------
  // Direction of a channel, resolving programmable endpoints
  // ----------------------------------------------------------------------
  function automatic logic fills_memory(input flyby_type fb,
                                        input logic [`CHAN_W-1:0] chan);
    logic [`CHAN_W-1:0] ep;
    ep = chan - `IDX_USB_EP_FIRST;
    fills_memory = 1'b0;
    unique case (fb)
      flyby_periph_to_mem:    fills_memory = 1'b1;
      flyby_either_direction: fills_memory = !i_USB_EP_TO_HOST[ep];
      flyby_mem_to_periph, flyby_none: fills_memory = 1'b0;
    endcase
  endfunction

  assign xfer_fill = fills_memory(xfer_flyby, i_XFER_CHAN);
  assign ret_rx    = fills_memory(ret_flyby, i_RETIRE_CHAN);

  dma_status_pack u_pack (
    .i_source    (ret_source),
    .i_rx        (ret_rx),
    .i_spi_mode  (i_SER_SPI_MODE[ret_port]),
    .i_match     (i_SER_MATCH),
    .i_buf_gap   (i_SER_BUF_GAP),
    .i_char_gap  (i_SER_CHAR_GAP),
    .i_brk       (i_SER_BREAK),
    .i_fe        (i_SER_FRAME_ERR),
    .i_pe        (i_SER_PARITY_ERR),
    .i_ovr       (i_SER_OVERRUN),
    .i_usb_state (i_USB_STATE),
    .i_usb_bit13 (i_USB_BIT13),
    .i_usb_sel   (i_USB_SETUP_SEL),
    .i_usb_addr  (i_USB_SETUP_ADDR),
    .i_usb_cfg   (i_USB_EP_CONFIG),
    .o_status    (ret_status)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    // Only wired channels pass their request on
    d.periph_req = i_PERIPH_REQ & `PERIPH_USED_MASK;
    d.usb_req    = i_USB_REQ & `USB_USED_MASK;

    // Transfer start: direction must agree with the full flag
    d.xfer_grant     = 1'b0;
    d.xfer_deny      = 1'b0;
    d.xfer_to_periph = q.xfer_to_periph;
    if (i_XFER_VALID) begin
      d.xfer_to_periph = !xfer_fill;
      if (xfer_source == src_none) begin
        d.xfer_deny = 1'b1;
      end else if (xfer_fill == i_XFER_FULL) begin
        d.xfer_deny = 1'b1;
      end else begin
        d.xfer_grant = 1'b1;
      end
    end

    // Retire: status and full flag written in one descriptor update
    d.desc_write  = 1'b0;
    d.retire_deny = 1'b0;
    if (i_RETIRE_VALID) begin
      if (ret_source == src_none || ret_rx == i_RETIRE_FULL) begin
        d.retire_deny = 1'b1;
      end else begin
        d.desc_write  = 1'b1;
        d.desc_usb    = i_RETIRE_USB;
        d.desc_chan   = i_RETIRE_CHAN;
        d.desc_status = ret_status;
        d.desc_full   = ret_rx;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q.periph_req     <= `REQ_RESET;
      q.usb_req        <= `REQ_RESET;
      q.xfer_grant     <= 1'b0;
      q.xfer_deny      <= 1'b0;
      q.xfer_to_periph <= 1'b0;
      q.desc_write     <= 1'b0;
      q.desc_usb       <= 1'b0;
      q.desc_chan      <= 4'h0;
      q.desc_status    <= `STATUS_RESET;
      q.desc_full      <= 1'b0;
      q.retire_deny    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_PERIPH_REQ     = q.periph_req;
  assign o_USB_REQ        = q.usb_req;
  assign o_XFER_GRANT     = q.xfer_grant;
  assign o_XFER_DENY      = q.xfer_deny;
  assign o_XFER_TO_PERIPH = q.xfer_to_periph;
  assign o_DESC_WRITE     = q.desc_write;
  assign o_DESC_USB       = q.desc_usb;
  assign o_DESC_CHAN      = q.desc_chan;
  assign o_DESC_STATUS    = q.desc_status;
  assign o_DESC_FULL      = q.desc_full;
  assign o_RETIRE_DENY    = q.retire_deny;

endmodule

// File: dma_status_pack.sv
// Builds the 16-bit descriptor status word for the retiring peripheral.
// Assumes the flag inputs are the peripheral's report for the completed frame.
`timescale 1ns/10ps
`include "dma_map_defines.svh"

module dma_status_pack
  import dma_map_pkg::*;
(
  // Channel context
  input  wire source_type             i_source,
  input  wire logic                   i_rx,
  input  wire logic                   i_spi_mode,
  // Serial receive flags
  input  wire logic [3:0]             i_match,
  input  wire logic                   i_buf_gap,
  input  wire logic                   i_char_gap,
  input  wire logic                   i_brk,
  input  wire logic                   i_fe,
  input  wire logic                   i_pe,
  input  wire logic                   i_ovr,
  // Endpoint report
  input  wire logic [1:0]             i_usb_state,
  input  wire logic                   i_usb_bit13,
  input  wire logic                   i_usb_sel,
  input  wire logic [`USB_FIELD_W-1:0] i_usb_addr,
  input  wire logic [`USB_FIELD_W-1:0] i_usb_cfg,
  // Packed word
  output      logic [`STATUS_W-1:0]   o_status
);

  always_comb begin
    o_status = `STATUS_RESET;
    unique case (i_source)
      src_serial: begin
        if (i_rx && !i_spi_mode) begin
          o_status = {i_match[0], i_match[1], i_match[2], i_match[3],
                      i_buf_gap, i_char_gap, 6'h00,
                      i_brk, i_fe, i_pe, i_ovr};
        end else if (i_rx) begin
          o_status = {i_match[0], i_match[1], i_match[2], i_match[3],
                      12'h000};
        end
      end
      src_usb: begin
        o_status = {i_usb_state, i_usb_bit13, i_usb_sel,
                    i_usb_sel ? i_usb_addr : i_usb_cfg};
      end
      src_printer, src_none: begin
        o_status = `STATUS_RESET;
      end
    endcase
  end

endmodule

// File: periph_report_model.sv
// Serial and endpoint peripherals: frame reports and raw request lines.
// Assumes the bench loads a report word; outputs change at the falling edge.
`timescale 1ns/10ps

module periph_report_model (
  // Clock and load
  input  wire logic        i_clk,
  input  wire logic [27:0] i_raw,
  input  wire logic [15:0] i_preq,
  input  wire logic [15:0] i_ureq,
  // Reports and requests
  output      logic [15:0] o_preq,
  output      logic [15:0] o_ureq,
  output      logic [3:0]  o_match,
  output      logic        o_buf_gap,
  output      logic        o_char_gap,
  output      logic        o_brk,
  output      logic        o_fe,
  output      logic        o_pe,
  output      logic        o_ovr,
  output      logic [1:0]  o_state,
  output      logic        o_bit13,
  output      logic        o_sel,
  output      logic [11:0] o_addr,
  output      logic [11:0] o_cfg
);
  initial begin
    {o_preq, o_ureq} = 32'h0;
    {o_ovr, o_pe, o_fe, o_brk, o_char_gap, o_buf_gap, o_match} = 10'h0;
    {o_state, o_bit13, o_sel, o_addr, o_cfg} = 28'h0;
  end
  // Report of the completed frame, held until the next load
  always @(negedge i_clk) begin
    o_preq <= i_preq;
    o_ureq <= i_ureq;
    {o_ovr, o_pe, o_fe, o_brk, o_char_gap, o_buf_gap, o_match} <= i_raw[9:0];
    {o_state, o_bit13, o_sel, o_addr, o_cfg} <= i_raw;
  end
endmodule

// File: testbench.sv
// Self-checking bench for the descriptor status word and the channel map.
// Assumes the design, its package, defines, checker and peripheral model.
`timescale 1ns/10ps
`include "dma_map_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module testbench;
  logic        clk, rst_n, xv, xu, xf, rv, ru, rf, exp_g;
  logic        buf_gap, char_gap, brk, fe, pe, ovr, bit13, sel, grant, deny, to_p;
  logic        dwr, dusb, dfull, rdeny;
  logic [1:0]  st, m;
  logic [3:0]  xc, rc, spi, match, dchan;
  logic [10:0] ep_dir;
  logic [11:0] addr, cfg;
  logic [15:0] preq_raw, ureq_raw, preq, ureq, o_preq, o_ureq, d_status;
  logic [27:0] raw;
  int          error_cnt, checked;

  periph_report_model i_model (.i_clk(clk), .i_raw(raw), .i_preq(preq_raw), .i_ureq(ureq_raw),
    .o_preq(preq), .o_ureq(ureq), .o_match(match), .o_buf_gap(buf_gap),
    .o_char_gap(char_gap), .o_brk(brk), .o_fe(fe), .o_pe(pe), .o_ovr(ovr), .o_state(st),
    .o_bit13(bit13), .o_sel(sel),
    .o_addr(addr), .o_cfg(cfg));

  dma_status_channel_map i_dut (.I_CLOCK(clk), .I_RST_N(rst_n), .i_PERIPH_REQ(preq),
    .i_USB_REQ(ureq), .i_XFER_VALID(xv), .i_XFER_USB(xu), .i_XFER_CHAN(xc), .i_XFER_FULL(xf),
    .i_RETIRE_VALID(rv), .i_RETIRE_USB(ru), .i_RETIRE_CHAN(rc), .i_RETIRE_FULL(rf),
    .i_SER_SPI_MODE(spi), .i_SER_MATCH(match), .i_SER_BUF_GAP(buf_gap),
    .i_SER_CHAR_GAP(char_gap),
    .i_SER_BREAK(brk), .i_SER_FRAME_ERR(fe), .i_SER_PARITY_ERR(pe), .i_SER_OVERRUN(ovr),
    .i_USB_STATE(st), .i_USB_BIT13(bit13), .i_USB_SETUP_SEL(sel), .i_USB_SETUP_ADDR(addr),
    .i_USB_EP_CONFIG(cfg), .i_USB_EP_TO_HOST(ep_dir), .o_PERIPH_REQ(o_preq),
    .o_USB_REQ(o_ureq), .o_XFER_GRANT(grant), .o_XFER_DENY(deny), .o_XFER_TO_PERIPH(to_p),
    .o_DESC_WRITE(dwr), .o_DESC_USB(dusb), .o_DESC_CHAN(dchan), .o_DESC_STATUS(d_status),
    .o_DESC_FULL(dfull), .o_RETIRE_DENY(rdeny));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Returns {used, memory to peripheral} of a channel
  function automatic logic [1:0] chan_map(input logic u, input logic [3:0] c);
    if (!u) begin
      if (c < 4'h8) return {1'b1, c[0]};
      if (c == 4'h8 || c == 4'ha) return 2'b10;
      if (c == 4'hb) return 2'b11;
      return 2'b00;
    end
    if (c == 4'h0) return 2'b10;
    if (c == 4'h1) return 2'b11;
    if (c <= 4'hc) return {1'b1, ep_dir[c - 4'h2]};
    return 2'b00;
  endfunction

  task automatic xfer(input logic u, input logic [3:0] c, input logic f);
    @(negedge clk);
    xu = u;
    xc = c;
    xf = f;
    xv = 1'b1;
    @(negedge clk);
    xv = 1'b0;
  endtask

  task automatic ret_chk(input logic u, input logic [3:0] c, input logic f,
                         input logic [27:0] r, input logic [7:0] ctl, input logic [15:0] s);
    @(negedge clk);
    raw = r;
    @(negedge clk);
    ru = u;
    rc = c;
    rf = f;
    rv = 1'b1;
    @(negedge clk);
    rv = 1'b0;
    `CHK({dwr, rdeny, dfull, dusb, dchan}, ctl)
    `CHK(d_status, s)
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    {rst_n, xv, xu, xf, rv, ru, rf, xc, rc, raw} = 43'h0;
    {preq_raw, ureq_raw} = 32'h0;
    spi = 4'b0001;
    ep_dir = 11'h555;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    `CHK({grant, deny, dwr, rdeny, d_status}, 20'h0)
    preq_raw = 16'hffff;
    ureq_raw = 16'hffff;
    repeat (3) @(negedge clk);
    `CHK(o_preq, 16'h0dff)
    `CHK(o_ureq, 16'h1fff)
    $display("test masks done");
    for (int u = 0; u < 2; u++) begin
      for (int c = 0; c < 16; c++) begin
        for (int f = 0; f < 2; f++) begin
          m = chan_map(u[0], c[3:0]);
          exp_g = m[1] && (f[0] == m[0]);
          xfer(u[0], c[3:0], f[0]);
          `CHK(grant, exp_g)
          `CHK(deny, !exp_g)
          if (exp_g) `CHK(to_p, m[0])
        end
      end
    end
    $display("test channel map done");
    ret_chk(1'b0, 4'h0, 1'b0, 28'hf000155, 8'ha0, 16'ha80a);
    ret_chk(1'b0, 4'h8, 1'b0, 28'hf000155, 8'ha8, 16'h0000);
    ret_chk(1'b0, 4'h2, 1'b0, 28'hf000155, 8'ha2, 16'ha000);
    ret_chk(1'b0, 4'h5, 1'b1, 28'hf000155, 8'h85, 16'h0000);
    ret_chk(1'b0, 4'hb, 1'b1, 28'hf0003ff, 8'h8b, 16'h0000);
    ret_chk(1'b1, 4'h2, 1'b1, 28'hb123456, 8'h92, 16'hb123);
    for (int s = 0; s < 4; s++) begin
      ret_chk(1'b1, 4'h1, 1'b1, {s[1:0], 26'h0abc456}, 8'h91, {s[1:0], 14'h0456});
    end
    ret_chk(1'b0, 4'h0, 1'b1, 28'hf000155, 8'h51, 16'hc456);
    ret_chk(1'b1, 4'he, 1'b0, 28'hf000155, 8'h51, 16'hc456);
    $display("test retire status done");
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK({o_preq, d_status, dusb}, 33'h0)
    ret_chk(1'b0, 4'h6, 1'b0, 28'hf00000f, 8'ha6, 16'hf000);
    $display("test second reset done");
    stop_test();
  end
endmodule
